// ### core/stop_eval.sv
// Advanced stop condition evaluator with an APB register slave.
// Assumes synchronous sensor inputs, a position feed from the trajectory and one 20 MHz clock.
`timescale 1ns/1ps
`include "stop_eval_regs.svh"

module stop_eval (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] sensor_in,
  input wire logic [31:0] motor_pos,
  input wire logic move_active,
  output logic move_dir_q,
  output logic decel_q,
  output logic [31:0] trig_pos_q,
  output logic [1:0] cur_state
);

  // ************************************************************
  // Register slave
  // ************************************************************
  stop_eval_pkg::stop_words_t words_q;
  logic [0:0] mode_q;
  logic cmd_dir_q;
  logic [15:0] div_q;
  logic start_pulse;
  logic abort_pulse;
  logic wr_en;
  logic rd_hit;
  stop_eval_pkg::move_flags_t flags_q;
  stop_eval_pkg::state_t state_q;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `SE_ADDR_SEL) || (a == `SE_ADDR_LVL) || (a == `SE_ADDR_CTRL) ||
              (a == `SE_ADDR_STAT) || (a == `SE_ADDR_TRIGPOS) || (a == `SE_ADDR_DIV);
  endfunction : addr_ok

  assign rd_hit = addr_ok(paddr);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_q <= {`SE_WORD_RESET, `SE_WORD_RESET};
      mode_q <= 1'b0;
      cmd_dir_q <= 1'b0;
      div_q <= `SE_DIV_RESET;
    end else if (wr_en) begin
      case (paddr)
        `SE_ADDR_SEL: words_q.sel <= pwdata[15:0]; // RL1
        `SE_ADDR_LVL: words_q.lvl <= pwdata[15:0]; // RL1
        `SE_ADDR_CTRL: begin
          cmd_dir_q <= pwdata[`SE_CTRL_DIR];
          mode_q[0] <= pwdata[`SE_CTRL_REC];
        end
        `SE_ADDR_DIV: div_q <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Start and abort are self-clearing strobes taken from control writes.
  assign start_pulse = wr_en && (paddr == `SE_ADDR_CTRL) && pwdata[`SE_CTRL_START];
  assign abort_pulse = wr_en && (paddr == `SE_ADDR_CTRL) && pwdata[`SE_CTRL_ABORT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SE_ADDR_SEL: prdata <= {16'h0000, words_q.sel};
        `SE_ADDR_LVL: prdata <= {16'h0000, words_q.lvl};
        `SE_ADDR_CTRL: prdata <= {29'h0, mode_q[0], cmd_dir_q, 1'b0};
        `SE_ADDR_STAT: prdata <= {26'h0, state_q == stop_eval_pkg::ST_DONE, move_dir_q,
                                  flags_q.reversed, flags_q.decel, flags_q.recorded,
                                  flags_q.triggered};
        `SE_ADDR_TRIGPOS: prdata <= trig_pos_q;
        `SE_ADDR_DIV: prdata <= {16'h0000, div_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Servo cycle tick and input sampling
  // ************************************************************
  logic [15:0] tick_cnt_q;
  logic servo_tick;
  logic [3:0] samp_q;

  assign servo_tick = (tick_cnt_q == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
    end else if (servo_tick) begin
      tick_cnt_q <= div_q - 16'h0001;
    end else begin
      tick_cnt_q <= tick_cnt_q - 16'h0001;
    end
  end

  // Sampling only on the servo tick keeps every check in one cycle on one consistent snapshot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q <= 4'h0;
    end else if (servo_tick) begin
      samp_q <= sensor_in; // RL18
    end
  end

  // ************************************************************
  // Condition evaluation
  // ************************************************************
  // A group matches per input when the sample equals the wanted level; unselected inputs drop out.
  function automatic logic [3:0] hits(input logic [3:0] s, input logic [3:0] sel,
                                      input logic [3:0] lvl);
    hits = sel & ~(s ^ lvl); // RL2 RL3 RL4
  endfunction : hits

  logic tog_q;
  logic [3:0] lvl_or;
  logic [3:0] lvl_and;
  logic rev_hit;
  logic sec_hit;
  logic or_hit;
  logic and_hit;
  logic last_hit;
  logic or_en;
  logic and_en;

  assign rev_hit = |hits({1'b0, samp_q[2:0]}, {1'b0, words_q.sel[`SE_REV_MSB:`SE_REV_LSB]},
                         {1'b0, words_q.lvl[`SE_REV_MSB:`SE_REV_LSB]}); // RL7
  assign sec_hit = (hits(samp_q, words_q.sel[`SE_SEC_MSB:`SE_SEC_LSB],
                         words_q.lvl[`SE_SEC_MSB:`SE_SEC_LSB])
                    == words_q.sel[`SE_SEC_MSB:`SE_SEC_LSB]);
  // Toggle inverts the final wanted levels once the reversal has fired.
  assign lvl_or = words_q.lvl[`SE_OR_MSB:`SE_OR_LSB] ^ {4{tog_q}}; // RL8
  assign lvl_and = words_q.lvl[`SE_AND_MSB:`SE_AND_LSB] ^ {4{tog_q}}; // RL8
  assign or_en = |words_q.sel[`SE_OR_MSB:`SE_OR_LSB];
  assign and_en = |words_q.sel[`SE_AND_MSB:`SE_AND_LSB];
  assign or_hit = |hits(samp_q, words_q.sel[`SE_OR_MSB:`SE_OR_LSB], lvl_or); // RL10
  assign and_hit = (hits(samp_q, words_q.sel[`SE_AND_MSB:`SE_AND_LSB], lvl_and)
                    == words_q.sel[`SE_AND_MSB:`SE_AND_LSB]); // RL11
  // With both groups enabled both must hold; an empty pair never stops.
  assign last_hit = (or_en || and_en) && (!or_en || or_hit) && (!and_en || and_hit); // RL15

  // ************************************************************
  // Move sequencer
  // ************************************************************
  logic sec_needed;
  assign sec_needed = |words_q.sel[`SE_SEC_MSB:`SE_SEC_LSB]; // RL17

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= stop_eval_pkg::ST_IDLE;
    end else if (abort_pulse || (!move_active && state_q != stop_eval_pkg::ST_IDLE &&
                                 !start_pulse)) begin
      // Move ended or aborted: from ST_SECOND the final check is simply never armed.
      state_q <= (state_q == stop_eval_pkg::ST_IDLE) ? stop_eval_pkg::ST_IDLE
                                                     : stop_eval_pkg::ST_DONE; // RL14
    end else if (start_pulse) begin
      state_q <= sec_needed ? stop_eval_pkg::ST_SECOND : stop_eval_pkg::ST_LAST;
    end else if (servo_tick) begin
      case (state_q)
        stop_eval_pkg::ST_SECOND: begin
          if (sec_hit) begin
            state_q <= stop_eval_pkg::ST_LAST; // RL14
          end
        end
        stop_eval_pkg::ST_LAST: begin
          if (last_hit && !mode_q[0]) begin
            state_q <= stop_eval_pkg::ST_DONE; // RL9
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Reversal is decided once from the snapshot held at the start write.
  // The commanded direction arrives in the same control write, so it is taken from the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_dir_q <= 1'b0;
      tog_q <= 1'b0;
      flags_q.reversed <= 1'b0;
    end else if (start_pulse) begin
      move_dir_q <= pwdata[`SE_CTRL_DIR] ^ rev_hit; // RL5 RL6
      tog_q <= rev_hit && words_q.lvl[`SE_TOG_BIT]; // RL8
      flags_q.reversed <= rev_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decel_q <= 1'b0;
      flags_q.decel <= 1'b0;
      flags_q.triggered <= 1'b0;
      flags_q.recorded <= 1'b0;
      trig_pos_q <= `SE_POS_RESET;
    end else if (start_pulse) begin
      decel_q <= 1'b0;
      flags_q.decel <= 1'b0;
      flags_q.triggered <= 1'b0;
      flags_q.recorded <= 1'b0;
    end else if (servo_tick && state_q == stop_eval_pkg::ST_LAST && last_hit) begin
      flags_q.triggered <= 1'b1;
      if (mode_q[0]) begin
        if (!flags_q.recorded) begin
          trig_pos_q <= motor_pos; // RL12
          flags_q.recorded <= 1'b1;
        end
      end else begin
        decel_q <= 1'b1; // RL9
        flags_q.decel <= 1'b1;
        trig_pos_q <= motor_pos; // RL16
      end
    end else if (!move_active) begin
      decel_q <= 1'b0;
    end
  end

  always_comb begin
    case (state_q)
      stop_eval_pkg::ST_SECOND: cur_state = 2'h1;
      stop_eval_pkg::ST_LAST: cur_state = 2'h2;
      stop_eval_pkg::ST_DONE: cur_state = 2'h3;
      default: cur_state = 2'h0;
    endcase
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_armed_hit;
    servo_tick && state_q == stop_eval_pkg::ST_LAST && last_hit && !start_pulse && move_active;
  endsequence

  a_decel_on_hit: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    (s_armed_hit and !mode_q[0]) |=> decel_q && trig_pos_q == $past(motor_pos))
    else $error("Final check met without deceleration.");

  a_record_no_halt: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    (s_armed_hit and (mode_q[0] && !flags_q.recorded && !decel_q))
      |=> !decel_q && flags_q.recorded && trig_pos_q == $past(motor_pos))
    else $error("Record mode halted or did not capture.");

  a_rev_dir: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    start_pulse |=> move_dir_q == ($past(pwdata[`SE_CTRL_DIR]) ^ $past(rev_hit)))
    else $error("Direction not reversed by first check.");

  a_rev_once: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    !start_pulse |=> $stable(move_dir_q))
    else $error("Direction changed after motion start.");

  a_no_last_early: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    state_q == stop_eval_pkg::ST_SECOND && !decel_q |=> !decel_q)
    else $error("Final check acted before second check.");

  a_second_arms: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    state_q == stop_eval_pkg::ST_SECOND && servo_tick && sec_hit && move_active && !abort_pulse
      && !start_pulse |=> state_q == stop_eval_pkg::ST_LAST)
    else $error("Second check met but last check not armed.");

  a_both_groups: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    or_en && and_en && last_hit |-> or_hit && and_hit)
    else $error("Combined groups stopped on one set.");

  a_sample_tick: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    !servo_tick |=> $stable(samp_q))
    else $error("Inputs sampled off the servo tick.");

  a_toggle_inv: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    tog_q |-> lvl_or == ~words_q.lvl[`SE_OR_MSB:`SE_OR_LSB])
    else $error("Toggle did not invert final levels.");

endmodule : stop_eval

// ### core/stop_eval_regs.svh
// Register offsets, field positions and reset values of the advanced stop evaluator.
// Assumes inclusion by the design module and the bench only.
//
// Functional notes
// RL1 - Command carries a 16-bit select word and 16-bit level word, each bit evaluated.
// RL2 - Select bit 1 includes the input in its group; 0 ignores it.
// RL3 - Level bit 1 means the wanted state is logic high.
// RL4 - Level bit 0 means the wanted state is logic low.
// RL5 - Reversal check is evaluated only at motion start, no later effect.
// RL6 - Satisfied reversal check runs the move opposite to the command.
// RL7 - Reversal check inputs are ORed together.
// RL8 - Toggle bit with fired reversal inverts final wanted levels.
// RL9 - Final stop condition true during a move starts deceleration.
// RL10 - OR mode: any selected input at wanted level satisfies the check.
// RL11 - AND mode: all selected inputs at wanted level simultaneously.
// RL12 - Record mode captures position and continues the move.
// RL13 - Host encodes words as decimal or hex before sending.
// RL14 - Second check never met: move completes, final check not evaluated.
// RL15 - AND and OR both enabled: both sets must be satisfied.
// RL16 - Final check met: stop and write trigger position register.
// RL17 - Fields: 3..0 OR, 7..4 AND, 11..8 second, 14..12 reversal, 15 toggle.
// RL18 - Inputs sampled once per servo cycle, conditions use synchronised samples.
`ifndef STOP_EVAL_REGS_SVH
`define STOP_EVAL_REGS_SVH

`define SE_ADDR_SEL 12'h000
`define SE_ADDR_LVL 12'h004
`define SE_ADDR_CTRL 12'h008
`define SE_ADDR_STAT 12'h00c
`define SE_ADDR_TRIGPOS 12'h010
`define SE_ADDR_DIV 12'h014

`define SE_OR_LSB 0
`define SE_OR_MSB 3
`define SE_AND_LSB 4
`define SE_AND_MSB 7
`define SE_SEC_LSB 8
`define SE_SEC_MSB 11
`define SE_REV_LSB 12
`define SE_REV_MSB 14
`define SE_TOG_BIT 15

`define SE_CTRL_START 0
`define SE_CTRL_DIR 1
`define SE_CTRL_REC 2
`define SE_CTRL_ABORT 3

`define SE_DIV_RESET 16'h0001
`define SE_WORD_RESET 16'h0000
`define SE_POS_RESET 32'h0000_0000

`endif

// ### core/stop_eval_pkg.sv
// Types shared by the advanced stop evaluator.
// Assumes the constants header sits beside it.
package stop_eval_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SECOND = 4'b0010,
    ST_LAST = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [15:0] lvl;
  } stop_words_t;

  typedef struct packed {
    logic reversed;
    logic decel;
    logic recorded;
    logic triggered;
  } move_flags_t;
endpackage : stop_eval_pkg

// ### tb/far_side.sv
// Far-side model: sensor front end and trajectory feed of the stop evaluator.
// Assumes the bench names the wanted levels; they reach the pins one clock later.
`timescale 1ns/1ps

module far_side (
  input wire logic pclk,
  input wire logic [3:0] want_in,
  input wire logic [31:0] want_pos,
  input wire logic want_run,
  output logic [3:0] sensor_in = 4'h0,
  output logic [31:0] motor_pos = 32'h0000_0000,
  output logic move_active = 1'b0
);
  // Levels move only on the clock, so the evaluator never sees a level change mid-cycle.
  always @(posedge pclk) begin
    sensor_in <= want_in;
    motor_pos <= want_pos;
    move_active <= want_run;
  end
endmodule : far_side

// ### tb/testbench.sv
// Self-checking bench for the stop evaluator: APB master, corner and random moves.
// Assumes the design, its header and the far-side model are compiled beforehand.
`timescale 1ns/1ps
`include "stop_eval_regs.svh"

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, trig_pos_q, motor_pos, rd;
  logic [31:0] exp_pos = 32'h0000_0000;
  logic pready, pslverr, move_active, move_dir_q, decel_q, err;
  logic [3:0] want_in = 4'h0;
  logic [3:0] sensor_in;
  logic [31:0] want_pos = 32'h0000_0000;
  logic want_run = 1'b0;
  logic [1:0] cur_state;
  int n_fail = 0;
  int comparisons = 0;

  stop_eval dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensor_in(sensor_in), .motor_pos(motor_pos),
    .move_active(move_active), .move_dir_q(move_dir_q), .decel_q(decel_q),
    .trig_pos_q(trig_pos_q), .cur_state(cur_state));
  far_side model (.pclk(pclk), .want_in(want_in), .want_pos(want_pos),
    .want_run(want_run), .sensor_in(sensor_in), .motor_pos(motor_pos),
    .move_active(move_active));

  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [3:0] hit(input logic [3:0] en, input logic [3:0] lv,
      input logic [3:0] s);
    return en & ~(lv ^ s);
  endfunction : hit

  function automatic logic sec(input logic [15:0] sel, input logic [15:0] lvl,
      input logic [3:0] s);
    return hit(sel[11:8], lvl[11:8], s) == sel[11:8];
  endfunction : sec

  // An empty AND group is met vacuously, an empty OR group only if AND is enabled.
  function automatic logic fin(input logic [15:0] sel, input logic [7:0] lv,
      input logic [3:0] s);
    logic o;
    o = |hit(sel[3:0], lv[3:0], s) || sel[3:0] == 4'h0;
    return (|sel[7:0]) && o && (hit(sel[7:4], lv[7:4], s) == sel[7:4]);
  endfunction : fin

  task automatic move(input logic [15:0] sel, input logic [15:0] lvl, input logic dir,
      input logic rec, input logic [3:0] s0, input logic [3:0] s1);
    logic rev, stop;
    logic [7:0] lv;
    logic [31:0] pos;
    int i;
    rev = |hit({1'b0, sel[14:12]}, {1'b0, lvl[14:12]}, s0);
    lv = lvl[7:0] ^ {8{rev & lvl[15]}};
    stop = (sec(sel, lvl, s0) && fin(sel, lv, s0)) ||
      (fin(sel, lv, s1) && (sec(sel, lvl, s0) || sec(sel, lvl, s1)));
    pos = exp_pos + 32'h0000_1000 + 32'($urandom_range(4095));
    want_in <= s0;
    want_pos <= pos;
    want_run <= 1'b1;
    apb(1'b1, `SE_ADDR_SEL, {16'hffff, sel});
    apb(1'b1, `SE_ADDR_LVL, {16'h0000, lvl});
    apb(1'b1, `SE_ADDR_CTRL, {28'h0000000, 1'b0, rec, dir, 1'b1});
    repeat (6) @(posedge pclk);
    check("direction", {31'h0, dir ^ rev}, {31'h0, move_dir_q});
    want_in <= s1;
    for (i = 0; i < 12; i++) begin
      @(posedge pclk);
      if (decel_q === 1'b1 || trig_pos_q === pos) break;
    end
    if (stop) begin
      exp_pos = pos;
    end
    check("decel", {31'h0, stop & ~rec}, {31'h0, decel_q});
    check("trigger position", exp_pos, trig_pos_q);
    check("direction held", {31'h0, dir ^ rev}, {31'h0, move_dir_q});
    apb(1'b0, `SE_ADDR_STAT, 32'h0);
    check("status", {26'h0, stop & ~rec, dir ^ rev, rev, stop & ~rec, stop & rec, stop},
      {26'h0, rd[5:0]});
    apb(1'b0, `SE_ADDR_TRIGPOS, 32'h0);
    check("position register", exp_pos, rd);
    apb(1'b0, `SE_ADDR_CTRL, 32'h0);
    check("control readback", {29'h0, rec, dir, 1'b0}, rd);
    want_run <= 1'b0;
    repeat (3) @(posedge pclk);
    check("decel released", 32'h0, {31'h0, decel_q});
    check("state", 32'h3, {30'h0, cur_state});
  endtask : move

  initial begin
    logic [15:0] s, l;
    void'($urandom(32'h700d6b27));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SE_ADDR_DIV, 32'h0);
    check("divider reset", {16'h0000, `SE_DIV_RESET}, rd);
    apb(1'b0, `SE_ADDR_SEL, 32'h0);
    check("select reset", 32'h0, rd);
    apb(1'b1, 12'h020, 32'h1234_5678);
    check("unmapped write", 32'h1, {31'h0, err});
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read", 32'h1, {31'h0, err});
    check("unmapped read data", 32'h0, rd);
    apb(1'b1, `SE_ADDR_SEL, 32'hffff_1234);
    apb(1'b0, `SE_ADDR_SEL, 32'h0);
    check("select width", 32'h0000_1234, rd);
    move(16'h1001, 16'h9001, 1'b0, 1'b0, 4'h0, 4'h1);
    move(16'h1001, 16'h9001, 1'b1, 1'b0, 4'h1, 4'h0);
    move(16'h1001, 16'h1001, 1'b0, 1'b0, 4'h1, 4'h0);
    move(16'h0002, 16'h0000, 1'b1, 1'b0, 4'h2, 4'h0);
    move(16'h0008, 16'h0008, 1'b0, 1'b0, 4'h0, 4'h8);
    move(16'h00f0, 16'h00f0, 1'b0, 1'b0, 4'h0, 4'h7);
    move(16'h0030, 16'h0030, 1'b1, 1'b0, 4'h0, 4'h3);
    move(16'h0021, 16'h0021, 1'b0, 1'b0, 4'h0, 4'h1);
    move(16'h0021, 16'h0021, 1'b0, 1'b0, 4'h0, 4'h3);
    move(16'h0201, 16'h0201, 1'b1, 1'b0, 4'h0, 4'h1);
    move(16'h0201, 16'h0201, 1'b0, 1'b0, 4'h0, 4'h3);
    move(16'h0004, 16'h0004, 1'b0, 1'b1, 4'h0, 4'h4);
    move(16'h4f00, 16'h4000, 1'b1, 1'b0, 4'h4, 4'h4);
    // An abort ends an armed move, so a later hit must not decelerate.
    want_in <= 4'h0;
    want_run <= 1'b1;
    apb(1'b1, `SE_ADDR_SEL, 32'h0000_0001);
    apb(1'b1, `SE_ADDR_LVL, 32'h0000_0001);
    apb(1'b1, `SE_ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, `SE_ADDR_CTRL, 32'h0000_0008);
    want_in <= 4'h1;
    repeat (8) @(posedge pclk);
    check("decel after abort", 32'h0, {31'h0, decel_q});
    check("state after abort", 32'h3, {30'h0, cur_state});
    want_run <= 1'b0;
    // A slower servo cycle makes the random moves see samples held between ticks.
    apb(1'b1, `SE_ADDR_DIV, 32'h0000_0003);
    apb(1'b0, `SE_ADDR_DIV, 32'h0);
    check("divider", 32'h0000_0003, rd);
    repeat (30) begin
      s = 16'($urandom);
      l = 16'($urandom);
      move(s, l, 1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom));
    end
    summarize();
  end
endmodule : testbench
